// file: pgf_consts.vh
// constants for the port glitch filter and pull-up block
`ifndef PGF_CONSTS_VH
`define PGF_CONSTS_VH

// register byte addresses
`define PGF_ADDR_W            16
`define PGF_FCLKDIV_ADDR      16'h30EF
`define PGF_PULLUP_ADDR       16'h30F0
`define PGF_FLTSEL_ADDR       16'h30F8
`define PGF_STAT_A_ADDR       16'h30F9
`define PGF_STAT_X_ADDR       16'h30FA

// reset values and write masks
`define PGF_FCLKDIV_RST       8'h00
`define PGF_PULLUP_RST        8'h00
`define PGF_PULLUP_WMASK      8'hEF
`define PGF_FLTSEL_RST        8'h00

// filter clock divider field positions
`define PGF_SLOW_LSB          5
`define PGF_MID_LSB           2
`define PGF_FAST_LSB          0

// filter select field positions
`define PGF_SEL_PA_LSB        0
`define PGF_SEL_KB0_LSB       2
`define PGF_SEL_KB1_LSB       4
`define PGF_SEL_RST_LSB       6

// filter select codes
`define PGF_SEL_BUS           2'h0
`define PGF_SEL_FAST          2'h1
`define PGF_SEL_MID           2'h2
`define PGF_SEL_SLOW          2'h3

// divider structure
`define PGF_BUS_CNT_W         12
`define PGF_LPO_CNT_W         7
`define PGF_FAST_BASE         3'h1
`define PGF_MID_BASE          4'h5

// filtered inputs: port a pins 0..7, keyboard 0, keyboard 1, reset/irq
`define PGF_NUM_FILT          11
`define PGF_IDX_KB0           8
`define PGF_IDX_KB1           9
`define PGF_IDX_RST           10

// open-drain pins with automatic pull-up release
`define PGF_I2C_PIN_LO        2
`define PGF_I2C_PIN_HI        3

`endif

// file: pgf_clock_divider.v
// filter sampling tick generator: two bus clock dividers and one low-power oscillator divider
`include "pgf_consts.vh"

module pgf_clock_divider (
  input  wire       clock_in,
  input  wire       resetn_in,
  input  wire       ce_in,
  input  wire       low_power_osc_clock_in,
  input  wire [1:0] fast_filter_divider_in,
  input  wire [2:0] mid_filter_divider_in,
  input  wire [2:0] slow_filter_divider_in,
  output wire       fast_tick_out,
  output wire       mid_tick_out,
  output wire       slow_tick_out
);

  reg  [`PGF_BUS_CNT_W-1:0] bus_cnt_q;
  reg  [`PGF_LPO_CNT_W-1:0] lpo_cnt_q;
  reg                       lpo_meta_q;
  reg                       lpo_sync_q;
  reg                       lpo_prev_q;
  wire                      lpo_edge;
  wire [`PGF_BUS_CNT_W-1:0] fast_mask;
  wire [`PGF_BUS_CNT_W-1:0] mid_mask;
  wire [`PGF_LPO_CNT_W-1:0] slow_mask;

  // divide by 2^(code+1) and 2^(code+5): tick when the low bits of a free counter are all ones
  assign fast_mask = ~({`PGF_BUS_CNT_W{1'b1}} << ({1'b0, fast_filter_divider_in} + `PGF_FAST_BASE));
  assign mid_mask  = ~({`PGF_BUS_CNT_W{1'b1}} << ({1'b0, mid_filter_divider_in} + `PGF_MID_BASE));
  assign slow_mask = ~({`PGF_LPO_CNT_W{1'b1}} << slow_filter_divider_in);

  assign lpo_edge      = lpo_sync_q & ~lpo_prev_q;
  assign fast_tick_out = ce_in & ((bus_cnt_q & fast_mask) == fast_mask);
  assign mid_tick_out  = ce_in & ((bus_cnt_q & mid_mask) == mid_mask);
  assign slow_tick_out = ce_in & lpo_edge & ((lpo_cnt_q & slow_mask) == slow_mask);

  // the oscillator is far slower than the bus clock, so edge detection after a synchroniser is exact
  always @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      bus_cnt_q  <= {`PGF_BUS_CNT_W{1'b0}};
      lpo_cnt_q  <= {`PGF_LPO_CNT_W{1'b0}};
      lpo_meta_q <= 1'b0;
      lpo_sync_q <= 1'b0;
      lpo_prev_q <= 1'b0;
    end
    else if (ce_in)
    begin
      bus_cnt_q  <= bus_cnt_q + {{(`PGF_BUS_CNT_W-1){1'b0}}, 1'b1};
      lpo_meta_q <= low_power_osc_clock_in;
      lpo_sync_q <= lpo_meta_q;
      lpo_prev_q <= lpo_sync_q;
      if (lpo_edge)
        lpo_cnt_q <= lpo_cnt_q + {{(`PGF_LPO_CNT_W-1){1'b0}}, 1'b1};
    end
  end

endmodule

// file: pgf_glitch_filter.v
// one input glitch filter: synchroniser plus two-sample agreement on the sampling tick
module pgf_glitch_filter (
  input  wire clock_in,
  input  wire resetn_in,
  input  wire ce_in,
  input  wire tick_in,
  input  wire bypass_in,
  input  wire pin_in,
  output wire filtered_out
);

  reg meta_q;
  reg sync_q;
  reg sample_q;
  reg out_q;

  assign filtered_out = out_q;

  // a pulse shorter than one tick period is sampled at most once and never wins agreement
  always @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      meta_q   <= 1'b0;
      sync_q   <= 1'b0;
      sample_q <= 1'b0;
      out_q    <= 1'b0;
    end
    else if (ce_in)
    begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      if (bypass_in)
      begin
        sample_q <= sync_q;
        out_q    <= sync_q;
      end
      else if (tick_in)
      begin
        sample_q <= sync_q;
        if (sync_q == sample_q)
          out_q <= sync_q;
      end
    end
  end

endmodule

// file: pgf_top.v
// port glitch filter clocking, input filters and port a pull-up control
`include "pgf_consts.vh"

module pgf_top (
  input  wire                   clock_in,
  input  wire                   resetn_in,
  input  wire                   ce_in,
  // register port
  input  wire [`PGF_ADDR_W-1:0] reg_addr_in,
  input  wire [7:0]             reg_wdata_in,
  input  wire                   reg_write_in,
  input  wire                   reg_read_in,
  output wire [7:0]             reg_rdata_out,
  // clocking and mode
  input  wire                   low_power_osc_clock_in,
  input  wire                   stop_mode_in,
  // raw inputs
  input  wire [7:0]             port_a_pin_in,
  input  wire                   keyboard0_in,
  input  wire                   keyboard1_in,
  input  wire                   reset_irq_in,
  // filtered inputs to internal logic
  output wire [7:0]             port_a_filtered_out,
  output wire                   keyboard0_filtered_out,
  output wire                   keyboard1_filtered_out,
  output wire                   reset_irq_filtered_out,
  // port a pin configuration from the data and direction logic
  input  wire [7:0]             port_a_output_en_in,
  input  wire [7:0]             port_a_input_en_in,
  input  wire [7:0]             port_a_out_data_in,
  input  wire [1:0]             port_a_i2c_mode_in,
  // pull-up device controls
  output wire [7:0]             port_a_pullup_out
);

  // ****************************************************************
  // registers and declarations
  // ****************************************************************
  reg  [7:0]                filter_clock_divider_q;
  reg  [7:0]                port_a_pullup_enable_q;
  reg  [7:0]                filter_select_q;
  reg  [7:0]                rdata_q;
  reg  [7:0]                rdata_d;
  reg  [7:0]                pullup_q;
  reg  [7:0]                pullup_d;

  wire [1:0]                fast_filter_divider;
  wire [2:0]                mid_filter_divider;
  wire [2:0]                slow_filter_divider;
  wire [1:0]                port_a_filter_select;
  wire [1:0]                keyboard0_filter_select;
  wire [1:0]                keyboard1_filter_select;
  wire [1:0]                reset_irq_filter_select;

  wire                      fast_tick;
  wire                      mid_tick;
  wire                      slow_tick;

  wire [`PGF_NUM_FILT-1:0]  raw_vec;
  wire [`PGF_NUM_FILT-1:0]  filt_vec;
  wire [`PGF_NUM_FILT-1:0]  tick_vec;
  wire [`PGF_NUM_FILT-1:0]  bypass_vec;

  wire                      wr_fclkdiv;
  wire                      wr_pullup;
  wire                      wr_fltsel;

  // ****************************************************************
  // field extraction
  // ****************************************************************
  assign fast_filter_divider     = filter_clock_divider_q[`PGF_FAST_LSB+1:`PGF_FAST_LSB];
  assign mid_filter_divider      = filter_clock_divider_q[`PGF_MID_LSB+2:`PGF_MID_LSB];
  assign slow_filter_divider     = filter_clock_divider_q[`PGF_SLOW_LSB+2:`PGF_SLOW_LSB];
  assign port_a_filter_select    = filter_select_q[`PGF_SEL_PA_LSB+1:`PGF_SEL_PA_LSB];
  assign keyboard0_filter_select = filter_select_q[`PGF_SEL_KB0_LSB+1:`PGF_SEL_KB0_LSB];
  assign keyboard1_filter_select = filter_select_q[`PGF_SEL_KB1_LSB+1:`PGF_SEL_KB1_LSB];
  assign reset_irq_filter_select = filter_select_q[`PGF_SEL_RST_LSB+1:`PGF_SEL_RST_LSB];

  // ****************************************************************
  // register write decode
  // ****************************************************************
  assign wr_fclkdiv = ce_in & reg_write_in & (reg_addr_in == `PGF_FCLKDIV_ADDR);
  assign wr_pullup  = ce_in & reg_write_in & (reg_addr_in == `PGF_PULLUP_ADDR);
  assign wr_fltsel  = ce_in & reg_write_in & (reg_addr_in == `PGF_FLTSEL_ADDR);

  always @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      filter_clock_divider_q <= `PGF_FCLKDIV_RST;
      port_a_pullup_enable_q <= `PGF_PULLUP_RST;
      filter_select_q        <= `PGF_FLTSEL_RST;
    end
    else
    begin
      if (wr_fclkdiv)
        filter_clock_divider_q <= reg_wdata_in;
      if (wr_pullup)
        port_a_pullup_enable_q <= reg_wdata_in & `PGF_PULLUP_WMASK;
      if (wr_fltsel)
        filter_select_q <= reg_wdata_in;
    end
  end

  // ****************************************************************
  // register read port
  // ****************************************************************
  // data stands only in the cycle after the strobe; zero otherwise and for unmapped addresses
  always @*
  begin
    rdata_d = 8'h00;
    if (reg_read_in)
    begin
      case (reg_addr_in)
        `PGF_FCLKDIV_ADDR: rdata_d = filter_clock_divider_q;
        `PGF_PULLUP_ADDR:  rdata_d = port_a_pullup_enable_q & `PGF_PULLUP_WMASK;
        `PGF_FLTSEL_ADDR:  rdata_d = filter_select_q;
        `PGF_STAT_A_ADDR:  rdata_d = filt_vec[7:0];
        `PGF_STAT_X_ADDR:  rdata_d = {5'h00, filt_vec[`PGF_IDX_RST], filt_vec[`PGF_IDX_KB1], filt_vec[`PGF_IDX_KB0]};
        default:           rdata_d = 8'h00;
      endcase
    end
  end

  always @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
      rdata_q <= 8'h00;
    else if (ce_in)
      rdata_q <= rdata_d;
  end

  assign reg_rdata_out = rdata_q;

  // ****************************************************************
  // filter sampling ticks
  // ****************************************************************
  pgf_clock_divider u_divider (
    .clock_in               (clock_in),
    .resetn_in              (resetn_in),
    .ce_in                  (ce_in),
    .low_power_osc_clock_in (low_power_osc_clock_in),
    .fast_filter_divider_in (fast_filter_divider),
    .mid_filter_divider_in  (mid_filter_divider),
    .slow_filter_divider_in (slow_filter_divider),
    .fast_tick_out          (fast_tick),
    .mid_tick_out           (mid_tick),
    .slow_tick_out          (slow_tick)
  );

  // ****************************************************************
  // tick selection
  // ****************************************************************
  // stop mode replaces bus-derived dividers with the slow tick on the keyboard and reset/irq filters only, because the bus clock halts there
  function select_tick;
    input [1:0] code;
    input       auto_slow;
    input       stop;
    input       t_fast;
    input       t_mid;
    input       t_slow;
    reg   [1:0] eff;
    begin
      eff = code;
      if (auto_slow && stop && ((code == `PGF_SEL_FAST) || (code == `PGF_SEL_MID)))
        eff = `PGF_SEL_SLOW;
      case (eff)
        `PGF_SEL_BUS:  select_tick = 1'b1;
        `PGF_SEL_FAST: select_tick = t_fast;
        `PGF_SEL_MID:  select_tick = t_mid;
        `PGF_SEL_SLOW: select_tick = t_slow;
        default:       select_tick = 1'b1;
      endcase
    end
  endfunction

  assign raw_vec = {reset_irq_in, keyboard1_in, keyboard0_in, port_a_pin_in};

  // ****************************************************************
  // input filters
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < `PGF_NUM_FILT; gi = gi + 1)
    begin : g_filt
      wire [1:0] sel;
      wire       auto_slow;
      if (gi == `PGF_IDX_KB0)
      begin : g_kb0
        assign sel       = keyboard0_filter_select;
        assign auto_slow = 1'b1;
      end
      else if (gi == `PGF_IDX_KB1)
      begin : g_kb1
        assign sel       = keyboard1_filter_select;
        assign auto_slow = 1'b1;
      end
      else if (gi == `PGF_IDX_RST)
      begin : g_rst
        assign sel       = reset_irq_filter_select;
        assign auto_slow = 1'b1;
      end
      else
      begin : g_pa
        assign sel       = port_a_filter_select;
        assign auto_slow = 1'b0;
      end

      assign tick_vec[gi]   = ce_in & select_tick(sel, auto_slow, stop_mode_in,
                                                  fast_tick, mid_tick, slow_tick);
      // reset/irq code 00 means no filtering at all
      assign bypass_vec[gi] = (gi == `PGF_IDX_RST) && (sel == `PGF_SEL_BUS);

      pgf_glitch_filter u_filter (
        .clock_in     (clock_in),
        .resetn_in    (resetn_in),
        .ce_in        (ce_in),
        .tick_in      (tick_vec[gi]),
        .bypass_in    (bypass_vec[gi]),
        .pin_in       (raw_vec[gi]),
        .filtered_out (filt_vec[gi])
      );
    end
  endgenerate

  assign port_a_filtered_out    = filt_vec[7:0];
  assign keyboard0_filtered_out = filt_vec[`PGF_IDX_KB0];
  assign keyboard1_filtered_out = filt_vec[`PGF_IDX_KB1];
  assign reset_irq_filtered_out = filt_vec[`PGF_IDX_RST];

  // ****************************************************************
  // port a pull-up control
  // ****************************************************************
  // pull-ups go to input-enabled, non-driven pins, and to open-drain pins 2 and 3 while driven high; others stay off to save power
  always @*
  begin : pullup_comb
    integer i;
    pullup_d = 8'h00;
    for (i = 0; i < 8; i = i + 1)
    begin
      pullup_d[i] = port_a_pullup_enable_q[i] & ~port_a_output_en_in[i]
                    & port_a_input_en_in[i];
    end
    if (port_a_i2c_mode_in[0] && port_a_output_en_in[`PGF_I2C_PIN_LO])
      pullup_d[`PGF_I2C_PIN_LO] = port_a_pullup_enable_q[`PGF_I2C_PIN_LO]
                                  & port_a_out_data_in[`PGF_I2C_PIN_LO];
    if (port_a_i2c_mode_in[1] && port_a_output_en_in[`PGF_I2C_PIN_HI])
      pullup_d[`PGF_I2C_PIN_HI] = port_a_pullup_enable_q[`PGF_I2C_PIN_HI]
                                  & port_a_out_data_in[`PGF_I2C_PIN_HI];
  end

  always @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
      pullup_q <= 8'h00;
    else if (ce_in)
      pullup_q <= pullup_d;
  end

  assign port_a_pullup_out = pullup_q;

endmodule

// file: pgf_pin_model.sv
// outside circuitry model: raw pin levels and the low-power oscillator
module pgf_pin_model #(
  parameter int OSC_HALF_NS = 20
) (
  input  logic        clock_in,
  output logic        low_power_osc_clock_out,
  output logic [10:0] pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // oscillator and pins
  // ********
  // phase offset keeps oscillator edges off the bus clock edges
  initial
  begin
    low_power_osc_clock_out = 1'b0;
    pin_out = 11'h000;
    #3;
    forever #OSC_HALF_NS low_power_osc_clock_out = ~low_power_osc_clock_out;
  end
  task automatic pulse(input int idx, input int width);
    pin_out[idx] <= ~pin_out[idx];
    repeat (width) @(posedge clock_in);
    pin_out[idx] <= ~pin_out[idx];
  endtask
endmodule

// file: pgf_top_assertions.sv
// concurrent checks on the register port and pull-up outputs
`include "pgf_consts.vh"
module pgf_top_assertions (
  input logic                   clock_in,
  input logic                   resetn_in,
  input logic                   ce_in,
  input logic [`PGF_ADDR_W-1:0] reg_addr_in,
  input logic [7:0]             reg_wdata_in,
  input logic                   reg_write_in,
  input logic                   reg_read_in,
  input logic [7:0]             reg_rdata_out,
  input logic [7:0]             port_a_filtered_out,
  input logic [7:0]             port_a_output_en_in,
  input logic [7:0]             port_a_input_en_in,
  input logic [7:0]             port_a_out_data_in,
  input logic [1:0]             port_a_i2c_mode_in,
  input logic [7:0]             port_a_pullup_out
);
  // ********
  // checks
  // ********
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  logic mapped;
  assign mapped = reg_addr_in inside {`PGF_FCLKDIV_ADDR, `PGF_PULLUP_ADDR, `PGF_FLTSEL_ADDR,
                                      `PGF_STAT_A_ADDR, `PGF_STAT_X_ADDR};
  sequence s_pu_write;
    ce_in && reg_write_in && reg_addr_in == `PGF_PULLUP_ADDR;
  endsequence
  sequence s_pu_read;
    ce_in && reg_read_in && reg_addr_in == `PGF_PULLUP_ADDR;
  endsequence
  chk_pu_readback: assert property (
    s_pu_write ##1 s_pu_read |=> reg_rdata_out == ($past(reg_wdata_in, 2) & `PGF_PULLUP_WMASK))
    else $error("pull-up readback wrong");
  chk_bad_read: assert property (ce_in && reg_read_in && !mapped |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  chk_rdata_idle: assert property ($past(ce_in) && !$past(reg_read_in) |-> reg_rdata_out == 8'h00)
    else $error("read data outside read slot");
  chk_bit4_off: assert property (port_a_pullup_out[4] == 1'b0)
    else $error("pull-up on reserved pin");
  chk_out_no_pu: assert property (ce_in |=> (port_a_pullup_out & $past(port_a_output_en_in) &
    ~{4'h0, $past(port_a_i2c_mode_in), 2'h0}) == 8'h00) else $error("pull-up on output pin");
  chk_hiz_no_pu: assert property (ce_in |=> (port_a_pullup_out & ~$past(port_a_output_en_in) &
    ~$past(port_a_input_en_in)) == 8'h00) else $error("pull-up on hi-z pin");
  chk_i2c_low_off: assert property (ce_in |=> (port_a_pullup_out[3:2] & $past(port_a_i2c_mode_in) &
    $past(port_a_output_en_in[3:2]) & ~$past(port_a_out_data_in[3:2])) == 2'h0)
    else $error("pull-up on low open-drain pin");
  chk_ce_freeze: assert property (!ce_in |=> $stable(reg_rdata_out) && $stable(port_a_pullup_out)
    && $stable(port_a_filtered_out)) else $error("state moved while clock enable low");
endmodule
bind pgf_top pgf_top_assertions chk_u (.clock_in, .resetn_in, .ce_in, .reg_addr_in, .reg_wdata_in,
  .reg_write_in, .reg_read_in, .reg_rdata_out, .port_a_filtered_out, .port_a_output_en_in,
  .port_a_input_en_in, .port_a_out_data_in, .port_a_i2c_mode_in, .port_a_pullup_out);

// file: tb.sv
// self-checking bench for the port glitch filter and pull-up block
`include "pgf_consts.vh"
`define CHECK(a, e) begin n_tests++; if ((a) !== (e)) begin errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int OSC_CYC = 5;
  logic clock_in, resetn_in, ce_in, we, re, stop, kb;
  logic [15:0] addr;
  logic [7:0] wd, oe, ie, od, rdata, pu, pa_f;
  logic [1:0] i2c;
  wire kb0_f, kb1_f, rst_f, osc;
  wire [10:0] pins, filt;
  int errors, n_tests;
  assign filt = {rst_f, kb1_f, kb0_f, pa_f};
  pgf_pin_model #(.OSC_HALF_NS(20)) pin_u (.clock_in, .low_power_osc_clock_out(osc), .pin_out(pins));
  pgf_top dut_u (.clock_in, .resetn_in, .ce_in, .reg_addr_in(addr), .reg_wdata_in(wd),
    .reg_write_in(we), .reg_read_in(re), .reg_rdata_out(rdata), .low_power_osc_clock_in(osc),
    .stop_mode_in(stop), .port_a_pin_in(pins[7:0]), .keyboard0_in(pins[8]), .keyboard1_in(pins[9]),
    .reset_irq_in(pins[10]), .port_a_filtered_out(pa_f), .keyboard0_filtered_out(kb0_f),
    .keyboard1_filtered_out(kb1_f), .reset_irq_filtered_out(rst_f), .port_a_output_en_in(oe),
    .port_a_input_en_in(ie), .port_a_out_data_in(od), .port_a_i2c_mode_in(i2c), .port_a_pullup_out(pu));
  // ********
  // helpers
  // ********
  initial
  begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end
  function automatic logic [7:0] exp_pu(logic [7:0] en, o, i, d, logic [1:0] m);
    logic [7:0] r;
    r = en & 8'hEF & ~o & i;
    for (int k = 2; k < 4; k++) if (m[k-2] && o[k]) r[k] = en[k] & d[k];
    return r;
  endfunction
  function automatic int per(int s, int c);
    return s == 0 ? 1 : s == 1 ? 2 << c : s == 2 ? 32 << c : OSC_CYC << c;
  endfunction
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    addr <= a;
    wd <= d;
    we <= 1'b1;
    @(posedge clock_in);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    addr <= a;
    re <= 1'b1;
    @(posedge clock_in);
    re <= 1'b0;
    @(negedge clock_in);
    d = rdata;
    @(posedge clock_in);
  endtask
  // pass is whether the filtered level must show the pulse at all
  task automatic filt_try(input int idx, input int w, input bit pass, input int p);
    int seen;
    seen = 0;
    fork pin_u.pulse(idx, w); join_none
    repeat (w + 2 * p + 8)
    begin
      @(posedge clock_in);
      if (filt[idx] === 1'b1) seen++;
    end
    `CHECK(seen > 0, pass)
    `CHECK(filt[idx], 1'b0)
  endtask
  task automatic try_div(input int s, input int c);
    int p, idx;
    p = per(s, c);
    idx = $urandom_range(0, 7);
    wr(`PGF_FLTSEL_ADDR, 8'(s));
    wr(`PGF_FCLKDIV_ADDR, s == 1 ? 8'(c) : s == 2 ? 8'(c << 2) : 8'(c << 5));
    filt_try(idx, p > 1 ? p - 1 : 1, 1'b0, p);
    filt_try(idx, 2 * p + 2, 1'b1, p);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (90000) @(posedge clock_in);
    errors++;
    give_verdict();
  end
  // ********
  // tests
  // ********
  initial
  begin
    logic [7:0] d, v, o, i, dd;
    logic [1:0] m;
    logic [15:0] ra [5];
    ra = '{`PGF_FCLKDIV_ADDR, `PGF_PULLUP_ADDR, `PGF_FLTSEL_ADDR, `PGF_STAT_A_ADDR, `PGF_STAT_X_ADDR};
    void'($urandom(40306));
    {ce_in, we, re, stop, addr, wd, oe, ie, od, i2c} = '0;
    ce_in = 1'b1;
    resetn_in = 1'b0;
    repeat (2) @(posedge clock_in);
    resetn_in <= 1'b1;
    @(posedge clock_in);
    foreach (ra[k])
    begin
      rd(ra[k], d);
      `CHECK(d, 8'h00)
    end
    wr(16'h3000, 8'hFF);
    rd(16'h3000, d);
    `CHECK(d, 8'h00)
    $display("test reset and unmapped done");
    for (int k = 0; k < 24; k++)
    begin
      {v, o, i, dd, m} = k == 0 ? {8'hFF, 8'h0C, 8'hFF, 8'h04, 2'h3} : 34'({$urandom, $urandom});
      oe <= o;
      ie <= i;
      od <= dd;
      i2c <= m;
      wr(`PGF_PULLUP_ADDR, v);
      rd(`PGF_PULLUP_ADDR, d);
      `CHECK(d, v & 8'hEF)
      @(negedge clock_in);
      `CHECK(pu, exp_pu(v, o, i, dd, m))
      @(posedge clock_in);
    end
    ce_in <= 1'b0;
    wr(`PGF_PULLUP_ADDR, ~v);
    ce_in <= 1'b1;
    rd(`PGF_PULLUP_ADDR, d);
    `CHECK(d, v & 8'hEF)
    $display("test pull-up done");
    try_div(0, 0);
    filt_try(10, 1, 1'b1, 1);
    for (int s = 1; s < 4; s++)
      for (int c = 0; c < (s == 1 ? 4 : 8); c++) try_div(s, c);
    $display("test filter clocks done");
    wr(`PGF_FLTSEL_ADDR, 8'h05);
    wr(`PGF_FCLKDIV_ADDR, 8'h60);
    stop <= 1'b1;
    filt_try(8, 6, 1'b0, per(3, 3));
    filt_try(0, 6, 1'b1, per(1, 0));
    stop <= 1'b0;
    filt_try(8, 6, 1'b1, per(1, 0));
    filt_try(9, 6, 1'b1, 1);
    $display("test stop mode done");
    resetn_in <= 1'b0;
    @(posedge clock_in);
    resetn_in <= 1'b1;
    @(posedge clock_in);
    rd(`PGF_PULLUP_ADDR, d);
    `CHECK(d, 8'h00)
    $display("test second reset done");
    give_verdict();
  end
endmodule
